// *** src/tmc_mode_ctrl.sv ***
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Coding select high enables encoder/decoder
// - Decode operation select into four modes
// - Standby input low means low power
// - Per-lane loopback routes serial output back
// - Default multipurpose output shows signalling type
// - Management picks per-lane multipurpose source
// - Pattern test inserts generator and checker
// - Pattern pass shown only when selected
// - Lockstep captures all lanes on lane0 clock
// - Lockstep presents receive data on lane0 clock
// - Chip reset recenters buffers, clears flags
// - Alignment input gates comma detection, realignment
// - Independent mode uses each lane's clocks
module tmc_mode_ctrl #(
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic codingSelect,
  input wire logic operation_select_lsb,
  input wire logic operation_select_msb,
  input wire logic standbyEnable,
  input wire logic [LANES-1:0] serial_loopback_enable,
  input wire logic pattern_test_enable,
  input wire logic lockstep_channels,
  input wire logic chip_reset_low,
  input wire logic alignment_enable,
  input wire logic factory_test_enable,
  input wire logic signallingIsHstl,
  input wire logic [LANES-1:0] signal_absent,
  input wire logic [LANES-1:0] alignment_symbol_seen,
  input wire logic [LANES-1:0] pattern_check_ok,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic coderEnable,
  output logic txPathEnable,
  output logic rxPathEnable,
  output logic repeaterEnable,
  output logic lowPowerStandby,
  output logic [LANES-1:0] loopbackRoute,
  output logic patternGenInsert,
  output logic patternCheckInsert,
  output logic [LANES-1:0] txLatchOnLane0Clock,
  output logic [LANES-1:0] rxOutOnLane0Clock,
  output logic txSkewRecenter,
  output logic rxSyncFifoRecenter,
  output logic byteAlignEnable,
  output logic [LANES-1:0] multipurpose_out
);
  import tmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Register fields are laid out for at most four lanes
  if (LANES < 1 || LANES > 4) begin : gBadLanes
    $error("tmc_mode_ctrl: LANES must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  localparam int SYNC_W = 9 + 4 * LANES;

  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncIn;

  logic codeS;
  logic [1:0] opS;
  logic standbyS;
  logic patternS;
  logic lockstepS;
  logic chipRunS;
  logic alignS;
  logic factoryS;
  logic hstlS;
  logic [LANES-1:0] loopS;
  logic [LANES-1:0] absentS;
  logic [LANES-1:0] seenS;
  logic [LANES-1:0] okS;

  assign rawIn = {
    codingSelect,
    operation_select_msb,
    operation_select_lsb,
    standbyEnable,
    pattern_test_enable,
    lockstep_channels,
    chip_reset_low,
    alignment_enable,
    factory_test_enable,
    serial_loopback_enable,
    signal_absent,
    alignment_symbol_seen,
    pattern_check_ok
  };

  // Synchroniser resets to zero, so chip reset reads as asserted
  tmc_sync #(
    .WIDTH(SYNC_W)
  ) inputSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  assign {codeS, opS, standbyS, patternS, lockstepS, chipRunS, alignS, factoryS,
          loopS, absentS, seenS, okS} = syncIn;

  // Pad status feeds the default multipurpose function and the lane status register; the former may
  // follow a pin strap; it is synchronised apart to keep it out of the bus
  logic hstlSync;
  tmc_sync #(
    .WIDTH(1)
  ) hstlSyncInst (
    .clk(clk),
    .rst(rst),
    .asyncIn(signallingIsHstl),
    .syncOut(hstlSync)
  );
  assign hstlS = hstlSync;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    tmc_mode_t mode;
    logic [TMC_MP_SEL_WIDTH*LANES-1:0] mpSelect;
    logic [LANES-1:0] absentFlag;
    logic [LANES-1:0] seenFlag;
    logic [LANES-1:0] failFlag;
    logic [31:0] rdData;
    logic coder;
    logic txEn;
    logic rxEn;
    logic repeater;
    logic standby;
    logic [LANES-1:0] loop;
    logic genIns;
    logic chkIns;
    logic [LANES-1:0] txLock;
    logic [LANES-1:0] rxLock;
    logic recenter;
    logic align;
    logic [LANES-1:0] mpOut;
  } tmc_core_state_t;

  tmc_core_state_t st_reg;
  tmc_core_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [1:0] laneSelect(
    input logic [TMC_MP_SEL_WIDTH*LANES-1:0] sel,
    input int lane
  );
    laneSelect = sel[lane*TMC_MP_SEL_WIDTH +: TMC_MP_SEL_WIDTH];
  endfunction

  function automatic logic [31:0] placeLanes(
    input logic [LANES-1:0] bits,
    input int pos
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[pos +: LANES] = bits;
    placeLanes = word;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic running;
  logic [LANES-1:0] flagClr;
  logic [31:0] rdWord;
  logic [31:0] cfgWord;
  logic [31:0] modeWord;

  always_comb begin
    st_next = st_reg;
    running = 1'b0;
    flagClr = '0;
    rdWord = 32'h0000_0000;
    cfgWord = 32'h0000_0000;
    modeWord = 32'h0000_0000;

    // Mode sequencing
    case (st_reg.mode)
      TMC_MODE_RESET: begin
        if (chipRunS) begin
          st_next.mode = standbyS ? TMC_MODE_RUN : TMC_MODE_STANDBY;
        end
      end
      TMC_MODE_STANDBY: begin
        if (!chipRunS) begin
          st_next.mode = TMC_MODE_RESET;
        end else if (standbyS) begin
          st_next.mode = TMC_MODE_RUN;
        end
      end
      TMC_MODE_RUN: begin
        if (!chipRunS) begin
          st_next.mode = TMC_MODE_RESET;
        end else if (!standbyS) begin
          st_next.mode = TMC_MODE_STANDBY;
        end
      end
      default: begin
        st_next.mode = TMC_MODE_RESET;
      end
    endcase

    running = (st_next.mode == TMC_MODE_RUN);

    // Buffers are recentered for as long as chip reset is held
    st_next.recenter = (st_next.mode == TMC_MODE_RESET);
    st_next.standby = (st_next.mode == TMC_MODE_STANDBY);

    // Path configuration; all paths idle outside run
    st_next.coder = running && codeS;
    st_next.txEn = running && (opS != TMC_OP_RX_ONLY);
    st_next.rxEn = running && (opS != TMC_OP_TX_ONLY);
    st_next.repeater = running && (opS == TMC_OP_REPEATER);
    st_next.loop = running ? loopS : '0;
    st_next.genIns = running && patternS;
    st_next.chkIns = running && patternS;
    st_next.align = running && alignS;

    // Clock source per lane; lane 0 always uses its own clock
    st_next.txLock = lockstepS ? {LANES{1'b1}} : '0;
    st_next.rxLock = lockstepS ? {LANES{1'b1}} : '0;

    // Register writes
    if (regWr) begin
      if (regAddr == TMC_OFS_MP_SELECT) begin
        st_next.mpSelect = regWrData[TMC_MP_SEL_WIDTH*LANES-1:0];
      end else if (regAddr == TMC_OFS_FLAGS) begin
        flagClr = regWrData[TMC_FL_ABSENT_POS +: LANES];
        st_next.absentFlag = st_reg.absentFlag & ~flagClr;
        st_next.seenFlag = st_reg.seenFlag & ~regWrData[TMC_FL_SEEN_POS +: LANES];
        st_next.failFlag = st_reg.failFlag & ~regWrData[TMC_FL_FAIL_POS +: LANES];
      end
    end

    // Sticky events; a set in the clearing cycle wins
    st_next.absentFlag = st_next.absentFlag | absentS;
    st_next.seenFlag = st_next.seenFlag | (seenS & {LANES{st_reg.align}});
    st_next.failFlag = st_next.failFlag | (~okS & {LANES{st_reg.chkIns}});

    // Chip reset clears the management flags
    if (!chipRunS) begin
      st_next.absentFlag = '0;
      st_next.seenFlag = '0;
      st_next.failFlag = '0;
    end

    // Multipurpose outputs
    for (int i = 0; i < LANES; i++) begin
      case (laneSelect(st_reg.mpSelect, i))
        TMC_MP_SIGNAL_TYPE: st_next.mpOut[i] = hstlS;
        TMC_MP_SIGNAL_ABSENT: st_next.mpOut[i] = absentS[i];
        TMC_MP_SYMBOL_SEEN: st_next.mpOut[i] = seenS[i] && st_reg.align;
        default: st_next.mpOut[i] = okS[i] && st_reg.chkIns;
      endcase
    end

    // Read views
    cfgWord[TMC_CV_CODE_POS] = codeS;
    cfgWord[TMC_CV_OP_POS +: 2] = opS;
    cfgWord[TMC_CV_STANDBY_POS] = standbyS;
    cfgWord[TMC_CV_PATTERN_POS] = patternS;
    cfgWord[TMC_CV_LOCKSTEP_POS] = lockstepS;
    cfgWord[TMC_CV_ALIGN_POS] = alignS;
    // Only reported; the board keeps this low
    cfgWord[TMC_CV_FACTORY_POS] = factoryS;
    cfgWord[TMC_CV_LOOP_POS +: LANES] = loopS;

    modeWord[1:0] = st_reg.mode;

    if (regAddr == TMC_OFS_MP_SELECT) begin
      rdWord[TMC_MP_SEL_WIDTH*LANES-1:0] = st_reg.mpSelect;
    end else if (regAddr == TMC_OFS_LANE_STATUS) begin
      rdWord = placeLanes(absentS, TMC_ST_ABSENT_POS)
             | placeLanes(seenS, TMC_ST_SEEN_POS)
             | placeLanes(okS, TMC_ST_OK_POS);
      rdWord[TMC_ST_HSTL_POS] = hstlS;
    end else if (regAddr == TMC_OFS_FLAGS) begin
      rdWord = placeLanes(st_reg.absentFlag, TMC_FL_ABSENT_POS)
             | placeLanes(st_reg.seenFlag, TMC_FL_SEEN_POS)
             | placeLanes(st_reg.failFlag, TMC_FL_FAIL_POS);
    end else if (regAddr == TMC_OFS_CONFIG_VIEW) begin
      rdWord = cfgWord;
    end else if (regAddr == TMC_OFS_MODE_VIEW) begin
      rdWord = modeWord;
    end else begin
      rdWord = 32'h0000_0000;
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdData = regRd ? rdWord : TMC_RST_READ_DATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mode <= TMC_MODE_RESET;
      st_reg.mpSelect <= TMC_RST_MP_SELECT[TMC_MP_SEL_WIDTH*LANES-1:0];
      st_reg.rdData <= TMC_RST_READ_DATA;
      st_reg.recenter <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign regRdData = st_reg.rdData;
  assign coderEnable = st_reg.coder;
  assign txPathEnable = st_reg.txEn;
  assign rxPathEnable = st_reg.rxEn;
  assign repeaterEnable = st_reg.repeater;
  assign lowPowerStandby = st_reg.standby;
  assign loopbackRoute = st_reg.loop;
  assign patternGenInsert = st_reg.genIns;
  assign patternCheckInsert = st_reg.chkIns;
  assign txLatchOnLane0Clock = st_reg.txLock;
  assign rxOutOnLane0Clock = st_reg.rxLock;
  assign txSkewRecenter = st_reg.recenter;
  assign rxSyncFifoRecenter = st_reg.recenter;
  assign byteAlignEnable = st_reg.align;
  assign multipurpose_out = st_reg.mpOut;

endmodule

`default_nettype wire

// *** src/tmc_pkg.sv ***
`default_nettype none

package tmc_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] TMC_OFS_MP_SELECT = 8'h00;
  localparam logic [7:0] TMC_OFS_LANE_STATUS = 8'h04;
  localparam logic [7:0] TMC_OFS_FLAGS = 8'h08;
  localparam logic [7:0] TMC_OFS_CONFIG_VIEW = 8'h0C;
  localparam logic [7:0] TMC_OFS_MODE_VIEW = 8'h10;

  // Reset values
  localparam logic [7:0] TMC_RST_MP_SELECT = 8'h00;
  localparam logic [31:0] TMC_RST_READ_DATA = 32'h0000_0000;

  // Multipurpose output source codes, two bits per lane
  localparam int TMC_MP_SEL_WIDTH = 2;
  localparam logic [1:0] TMC_MP_SIGNAL_TYPE = 2'h0;
  localparam logic [1:0] TMC_MP_SIGNAL_ABSENT = 2'h1;
  localparam logic [1:0] TMC_MP_SYMBOL_SEEN = 2'h2;
  localparam logic [1:0] TMC_MP_PATTERN = 2'h3;

  // Operation select codes {msb, lsb}
  localparam logic [1:0] TMC_OP_TRANSCEIVER = 2'h0;
  localparam logic [1:0] TMC_OP_TX_ONLY = 2'h1;
  localparam logic [1:0] TMC_OP_RX_ONLY = 2'h2;
  localparam logic [1:0] TMC_OP_REPEATER = 2'h3;

  // Lane status register field positions
  localparam int TMC_ST_ABSENT_POS = 0;
  localparam int TMC_ST_SEEN_POS = 4;
  localparam int TMC_ST_OK_POS = 8;
  localparam int TMC_ST_HSTL_POS = 12;

  // Flags register field positions
  localparam int TMC_FL_ABSENT_POS = 0;
  localparam int TMC_FL_SEEN_POS = 4;
  localparam int TMC_FL_FAIL_POS = 8;

  // Config view field positions
  localparam int TMC_CV_CODE_POS = 0;
  localparam int TMC_CV_OP_POS = 1;
  localparam int TMC_CV_STANDBY_POS = 3;
  localparam int TMC_CV_PATTERN_POS = 4;
  localparam int TMC_CV_LOCKSTEP_POS = 5;
  localparam int TMC_CV_ALIGN_POS = 6;
  localparam int TMC_CV_FACTORY_POS = 7;
  localparam int TMC_CV_LOOP_POS = 8;

  // Synchroniser stages
  localparam int TMC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    TMC_MODE_RESET,
    TMC_MODE_STANDBY,
    TMC_MODE_RUN
  } tmc_mode_t;

endpackage

`default_nettype wire

// *** src/tmc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  import tmc_pkg::*;

  if (WIDTH < 1) begin : gBadWidth
    $error("tmc_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } tmc_sync_state_t;

  tmc_sync_state_t syncState_reg;
  tmc_sync_state_t syncState_next;

  // First stage feeds only the second stage
  always_comb begin
    syncState_next = syncState_reg;
    syncState_next.stage1 = asyncIn;
    syncState_next.stage2 = syncState_reg.stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncState_reg <= '0;
    end else begin
      syncState_reg <= syncState_next;
    end
  end

  assign syncOut = syncState_reg.stage2;

endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import tmc_pkg::*;
  `define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
  logic clk = 0, rst = 1, cs = 0, opL = 0, opM = 0, sb = 1, pat = 0, lock = 0;
  logic aln = 0, hstl = 0, rr = 0, rw = 0, resetReq = 1;
  logic [3:0] lp = 4'h0, abs = 4'h0, seen = 4'h0, ok = 4'h0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0, d;
  logic crl, fte, coder, txE, rxE, rep, lps, pg, pc, tsr, rsr, bae;
  logic [3:0] lbr, txl, rxl, mpo;
  int miscompares = 0, checkCount = 0;
  always #5 clk = ~clk;
  tmc_host_model host (.clk(clk), .resetReq(resetReq), .chip_reset_low(crl),
    .factory_test_enable(fte));
  tmc_mode_ctrl dut (.clk(clk), .rst(rst), .codingSelect(cs), .operation_select_lsb(opL),
    .operation_select_msb(opM), .standbyEnable(sb), .serial_loopback_enable(lp),
    .pattern_test_enable(pat), .lockstep_channels(lock), .chip_reset_low(crl),
    .alignment_enable(aln), .factory_test_enable(fte), .signallingIsHstl(hstl),
    .signal_absent(abs), .alignment_symbol_seen(seen), .pattern_check_ok(ok),
    .regAddr(ra), .regWrData(wd), .regWr(rw), .regRd(rr), .regRdData(d),
    .coderEnable(coder), .txPathEnable(txE), .rxPathEnable(rxE), .repeaterEnable(rep),
    .lowPowerStandby(lps), .loopbackRoute(lbr), .patternGenInsert(pg),
    .patternCheckInsert(pc), .txLatchOnLane0Clock(txl), .rxOutOnLane0Clock(rxl),
    .txSkewRecenter(tsr), .rxSyncFifoRecenter(rsr), .byteAlignEnable(bae),
    .multipurpose_out(mpo));
  //////////////////////////////////////////////////////////////////
  task automatic w(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk) begin rw <= 1; ra <= a; wd <= v; end
    @(posedge clk) rw <= 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk) begin rr <= 1; ra <= a; end
    @(posedge clk) rr <= 0;
    #1 v = d;
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_ops();
    logic [31:0] v, e;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin {opM, opL} <= i[1:0]; cs <= i[0]; end
      w(6);
      `CHK("tx", i[1:0] != TMC_OP_RX_ONLY, txE)
      `CHK("rx", i[1:0] != TMC_OP_TX_ONLY, rxE)
      `CHK("rep", i[1:0] == TMC_OP_REPEATER, rep)
      `CHK("coder", i[0], coder)
    end
    rd(TMC_OFS_MODE_VIEW, v);
    `CHK("mode", 32'(TMC_MODE_RUN), v)
    wr(TMC_OFS_MODE_VIEW, 32'h0);
    rd(TMC_OFS_MODE_VIEW, v);
    `CHK("mode read only", 32'(TMC_MODE_RUN), v)
    e = (32'h1 << TMC_CV_CODE_POS) | (32'h3 << TMC_CV_OP_POS);
    e[TMC_CV_STANDBY_POS] = 1'b1;
    rd(TMC_OFS_CONFIG_VIEW, v);
    `CHK("config view", e, v)
    rd(8'hFC, v);
    `CHK("unmapped", 32'h0, v)
    rd(TMC_OFS_MP_SELECT, v);
    `CHK("sel reset", {24'h0, TMC_RST_MP_SELECT}, v)
  endtask
  task automatic t_standby();
    @(posedge clk) sb <= 0;
    w(6);
    `CHK("standby", 1'b1, lps)
    `CHK("tx off", 1'b0, txE)
    @(posedge clk) sb <= 1;
    w(6);
    `CHK("awake", 1'b0, lps)
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin lp <= 4'h1 << i; lock <= i[0]; pat <= i[1]; aln <= !i[0]; end
      w(6);
      `CHK("loop", 4'h1 << i, lbr)
      `CHK("txl", {4{i[0]}}, txl)
      `CHK("rxl", {4{i[0]}}, rxl)
      `CHK("pgen", i[1], pg)
      `CHK("pchk", i[1], pc)
      `CHK("align", !i[0], bae)
    end
  endtask
  task automatic t_mf();
    logic [31:0] v, e;
    @(posedge clk) begin hstl <= 1; pat <= 0; aln <= 1; end
    w(6);
    `CHK("mpo hstl", 4'hF, mpo)
    @(posedge clk) hstl <= 0;
    w(6);
    `CHK("mpo sstl", 4'h0, mpo)
    wr(TMC_OFS_MP_SELECT, {24'h0, TMC_MP_SIGNAL_TYPE, TMC_MP_PATTERN, TMC_MP_SYMBOL_SEEN,
      TMC_MP_SIGNAL_ABSENT});
    @(posedge clk) begin hstl <= 1; abs <= 4'h1; seen <= 4'h2; ok <= 4'h4; end
    w(6);
    `CHK("mpo no pattern", 4'hB, mpo)
    e = 32'h0;
    e[TMC_ST_ABSENT_POS +: 4] = 4'h1;
    e[TMC_ST_SEEN_POS +: 4] = 4'h2;
    e[TMC_ST_OK_POS +: 4] = 4'h4;
    e[TMC_ST_HSTL_POS] = 1'b1;
    rd(TMC_OFS_LANE_STATUS, v);
    `CHK("lane status", e, v)
    @(posedge clk) pat <= 1;
    w(6);
    `CHK("mpo all", 4'hF, mpo)
    @(posedge clk) aln <= 0;
    w(6);
    `CHK("mpo no align", 4'hD, mpo)
    @(posedge clk) begin abs <= 4'h0; pat <= 0; end
    w(6);
    rd(TMC_OFS_FLAGS, v);
    `CHK("flag set", 1'b1, v[0])
    wr(TMC_OFS_FLAGS, 32'h1);
    rd(TMC_OFS_FLAGS, v);
    `CHK("flag clr", 1'b0, v[0])
  endtask
  task automatic t_chipreset();
    logic [31:0] v;
    @(posedge clk) abs <= 4'hF;
    w(6);
    @(posedge clk) begin resetReq <= 1; abs <= 4'h0; seen <= 4'h0; end
    w(8);
    `CHK("tx recenter", 1'b1, tsr)
    `CHK("rx recenter", 1'b1, rsr)
    @(posedge clk) resetReq <= 0;
    w(8);
    `CHK("recenter off", 1'b0, tsr)
    rd(TMC_OFS_FLAGS, v);
    `CHK("flags cleared", 32'h0, v)
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk) resetReq <= 0;
    w(8);
    t_ops();
    t_standby();
    t_pins();
    t_mf();
    t_chipreset();
    conclude();
  end
endmodule

`default_nettype wire

// *** verif/tmc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmc_host_model (
  input wire logic clk,
  input wire logic resetReq,
  output logic chip_reset_low,
  output logic factory_test_enable
);
  // Board keeps the manufacturing input low at all times
  assign factory_test_enable = 1'b0;
  always_ff @(posedge clk) begin
    chip_reset_low <= !resetReq;
  end
endmodule

`default_nettype wire

// *** verif/tmc_mode_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmc_mode_checker #(
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic codingSelect,
  input wire logic operation_select_lsb,
  input wire logic operation_select_msb,
  input wire logic standbyEnable,
  input wire logic [LANES-1:0] serial_loopback_enable,
  input wire logic pattern_test_enable,
  input wire logic lockstep_channels,
  input wire logic alignment_enable,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic coderEnable,
  input wire logic txPathEnable,
  input wire logic rxPathEnable,
  input wire logic repeaterEnable,
  input wire logic lowPowerStandby,
  input wire logic [LANES-1:0] loopbackRoute,
  input wire logic patternGenInsert,
  input wire logic patternCheckInsert,
  input wire logic [LANES-1:0] txLatchOnLane0Clock,
  input wire logic [LANES-1:0] rxOutOnLane0Clock,
  input wire logic txSkewRecenter,
  input wire logic rxSyncFifoRecenter,
  input wire logic byteAlignEnable
);
  logic [2:0] age_reg;
  logic aged;
  logic run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Age gate keeps $past depth 3 clear of reset history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  assign aged = (age_reg >= 3'h4);
  assign run = aged && !txSkewRecenter && !lowPowerStandby;
  //////////////////////////////////////////////////////////////////
  recenter_pair_a: assert property (txSkewRecenter == rxSyncFifoRecenter)
    else $error("recenter outputs differ");
  reset_paths_a: assert property (txSkewRecenter |-> !txPathEnable && !rxPathEnable)
    else $error("path enabled during chip reset");
  coder_follow_a: assert property (run |-> coderEnable == $past(codingSelect, 3))
    else $error("coder enable wrong");
  op_decode_a: assert property (run |-> {txPathEnable, rxPathEnable, repeaterEnable} ==
    {!($past(operation_select_msb, 3) && !$past(operation_select_lsb, 3)),
     !($past(operation_select_lsb, 3) && !$past(operation_select_msb, 3)),
     $past(operation_select_msb, 3) && $past(operation_select_lsb, 3)})
    else $error("operation decode wrong");
  standby_follow_a: assert property (aged && !txSkewRecenter |->
    lowPowerStandby == !$past(standbyEnable, 3))
    else $error("standby wrong");
  loop_follow_a: assert property (run |-> loopbackRoute == $past(serial_loopback_enable, 3))
    else $error("loopback route wrong");
  pattern_insert_a: assert property (run |->
    patternGenInsert == $past(pattern_test_enable, 3) &&
    patternCheckInsert == $past(pattern_test_enable, 3))
    else $error("pattern insert wrong");
  lockstep_tx_a: assert property (aged |-> txLatchOnLane0Clock ==
    {LANES{$past(lockstep_channels, 3)}})
    else $error("lockstep capture wrong");
  lockstep_rx_a: assert property (rxOutOnLane0Clock == txLatchOnLane0Clock)
    else $error("lockstep receive wrong");
  align_follow_a: assert property (run |-> byteAlignEnable == $past(alignment_enable, 3))
    else $error("alignment enable wrong");
  read_quiet_a: assert property (regRdData != 32'h0000_0000 |-> $past(regRd))
    else $error("read data outside read slot");
endmodule

bind tmc_mode_ctrl tmc_mode_checker #(.LANES(LANES)) chk (.clk, .rst, .codingSelect,
  .operation_select_lsb, .operation_select_msb, .standbyEnable, .serial_loopback_enable,
  .pattern_test_enable, .lockstep_channels, .alignment_enable, .regRd, .regRdData,
  .coderEnable, .txPathEnable, .rxPathEnable, .repeaterEnable, .lowPowerStandby,
  .loopbackRoute, .patternGenInsert, .patternCheckInsert, .txLatchOnLane0Clock,
  .rxOutOnLane0Clock, .txSkewRecenter, .rxSyncFifoRecenter, .byteAlignEnable);

`default_nettype wire
